//--- rtl/coherency_slave_port_frontend.sv
// How it works
// - read coherent when shared and modifiable set
// - coherent read hit returns processor data
// - coherent read miss goes out, lock dropped
// - other reads pass straight to master
// - write coherent when shared and modifiable set
// - coherent write first cleans holding line
// - then write goes out, lock dropped
// - other writes pass straight to master
// - integer ratios only, single clock enable
// - slave side acts only on enabled edges
// - partial first-beat strobes never take optimized path
// - exclusive accesses pass for non-coherent regions
// - sixty-four bit slave data path
`timescale 1ns/1ps
`default_nettype none
`include "csp_defines.svh"

module coherency_slave_port_frontend #(
  parameter int ADDR_W = 32,
  parameter int ID_W = 3
) (
  input wire logic i_clk, // core clock
  input wire logic i_nrst, // async reset, low
  input wire logic i_slave_port_clock_enable, // slave port enable
  input wire logic i_s_arvalid, // slave ar valid
  output logic o_s_arready, // slave ar ready
  input wire logic [ADDR_W-1:0] i_s_araddr, // slave ar addr
  input wire logic [ID_W-1:0] i_s_arid, // slave ar id
  input wire logic [`CSP_LEN_W-1:0] i_s_arlen, // slave ar len
  input wire logic [`CSP_SIZE_W-1:0] i_s_arsize, // slave ar size
  input wire logic [`CSP_BURST_W-1:0] i_s_arburst, // slave ar burst
  input wire logic [`CSP_LOCK_W-1:0] i_s_arlock, // slave ar lock
  input wire logic [`CSP_CACHE_W-1:0] i_s_arcache, // slave ar cache
  input wire logic [`CSP_PROT_W-1:0] i_s_arprot, // slave ar prot
  input wire logic [`CSP_USER_W-1:0] i_s_aruser, // slave ar user
  output logic o_s_rvalid, // slave r valid
  input wire logic i_s_rready, // slave r ready
  output logic [`CSP_DATA_W-1:0] o_s_rdata, // slave r data
  output logic [ID_W-1:0] o_s_rid, // slave r id
  output logic [`CSP_RESP_W-1:0] o_s_rresp, // slave r resp
  output logic o_s_rlast, // slave r last
  input wire logic i_s_awvalid, // slave aw valid
  output logic o_s_awready, // slave aw ready
  input wire logic [ADDR_W-1:0] i_s_awaddr, // slave aw addr
  input wire logic [ID_W-1:0] i_s_awid, // slave aw id
  input wire logic [`CSP_LEN_W-1:0] i_s_awlen, // slave aw len
  input wire logic [`CSP_SIZE_W-1:0] i_s_awsize, // slave aw size
  input wire logic [`CSP_BURST_W-1:0] i_s_awburst, // slave aw burst
  input wire logic [`CSP_LOCK_W-1:0] i_s_awlock, // slave aw lock
  input wire logic [`CSP_CACHE_W-1:0] i_s_awcache, // slave aw cache
  input wire logic [`CSP_PROT_W-1:0] i_s_awprot, // slave aw prot
  input wire logic [`CSP_USER_W-1:0] i_s_awuser, // slave aw user
  input wire logic i_s_wvalid, // slave w valid
  output logic o_s_wready, // slave w ready
  input wire logic [`CSP_DATA_W-1:0] i_s_wdata, // slave w data
  input wire logic [`CSP_STRB_W-1:0] i_s_wstrb, // slave w strobes
  input wire logic i_s_wlast, // slave w last
  output logic o_s_bvalid, // slave b valid
  input wire logic i_s_bready, // slave b ready
  output logic [ID_W-1:0] o_s_bid, // slave b id
  output logic [`CSP_RESP_W-1:0] o_s_bresp, // slave b resp
  output logic o_m_arvalid, // master ar valid
  input wire logic i_m_arready, // master ar ready
  output logic [ADDR_W-1:0] o_m_araddr, // master ar addr
  output logic [ID_W-1:0] o_m_arid, // master ar id
  output logic [`CSP_LEN_W-1:0] o_m_arlen, // master ar len
  output logic [`CSP_SIZE_W-1:0] o_m_arsize, // master ar size
  output logic [`CSP_BURST_W-1:0] o_m_arburst, // master ar burst
  output logic [`CSP_LOCK_W-1:0] o_m_arlock, // master ar lock
  output logic [`CSP_CACHE_W-1:0] o_m_arcache, // master ar cache
  output logic [`CSP_PROT_W-1:0] o_m_arprot, // master ar prot
  output logic [`CSP_USER_W-1:0] o_m_aruser, // master ar user
  input wire logic i_m_rvalid, // master r valid
  output logic o_m_rready, // master r ready
  input wire logic [`CSP_DATA_W-1:0] i_m_rdata, // master r data
  input wire logic [ID_W-1:0] i_m_rid, // master r id
  input wire logic [`CSP_RESP_W-1:0] i_m_rresp, // master r resp
  input wire logic i_m_rlast, // master r last
  output logic o_m_awvalid, // master aw valid
  input wire logic i_m_awready, // master aw ready
  output logic [ADDR_W-1:0] o_m_awaddr, // master aw addr
  output logic [ID_W-1:0] o_m_awid, // master aw id
  output logic [`CSP_LEN_W-1:0] o_m_awlen, // master aw len
  output logic [`CSP_SIZE_W-1:0] o_m_awsize, // master aw size
  output logic [`CSP_BURST_W-1:0] o_m_awburst, // master aw burst
  output logic [`CSP_LOCK_W-1:0] o_m_awlock, // master aw lock
  output logic [`CSP_CACHE_W-1:0] o_m_awcache, // master aw cache
  output logic [`CSP_PROT_W-1:0] o_m_awprot, // master aw prot
  output logic [`CSP_USER_W-1:0] o_m_awuser, // master aw user
  output logic o_m_wvalid, // master w valid
  input wire logic i_m_wready, // master w ready
  output logic [`CSP_DATA_W-1:0] o_m_wdata, // master w data
  output logic [`CSP_STRB_W-1:0] o_m_wstrb, // master w strobes
  output logic o_m_wlast, // master w last
  input wire logic i_m_bvalid, // master b valid
  output logic o_m_bready, // master b ready
  input wire logic [ID_W-1:0] i_m_bid, // master b id
  input wire logic [`CSP_RESP_W-1:0] i_m_bresp, // master b resp
  output logic o_snoop_rd_req, // read lookup req
  output logic o_snoop_rd_opt, // read opt path
  input wire logic i_snoop_rd_ack, // lookup done
  input wire logic i_snoop_rd_hit, // held in a cpu
  input wire logic i_snoop_rvalid, // hit data valid
  output logic o_snoop_rready, // hit data ready
  input wire logic [`CSP_DATA_W-1:0] i_snoop_rdata, // hit data
  input wire logic i_snoop_rlast, // hit data last
  output logic o_snoop_wr_req, // clean-inv req
  output logic o_snoop_wr_opt, // write opt path
  input wire logic i_snoop_wr_ack // clean-inv done
);
  import csp_pkg::*;

  rd_state_type rd_state_ff;
  wr_state_type wr_state_ff;
  logic ce;
  logic ar_take, aw_take, ar_coh, aw_coh, aw_shape;
  logic r_take_m, r_take_s, r_out, r_done, nxt_rvalid;
  logic w_take, w_out, w_done, nxt_wvalid;
  logic b_take, b_out, nxt_bvalid;

  assign ce = i_slave_port_clock_enable;
  assign ar_take = ce && i_s_arvalid && o_s_arready;
  assign aw_take = ce && i_s_awvalid && o_s_awready;
  assign ar_coh = is_coherent(i_s_aruser, i_s_arcache);
  assign aw_coh = is_coherent(i_s_awuser, i_s_awcache);

  req_attr_capture #(.ADDR_W(ADDR_W), .ID_W(ID_W)) u_ar_cap (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_take(ar_take),
    .i_addr(i_s_araddr), .i_id(i_s_arid), .i_len(i_s_arlen),
    .i_size(i_s_arsize), .i_burst(i_s_arburst), .i_lock(i_s_arlock),
    .i_cache(i_s_arcache), .i_prot(i_s_arprot), .i_user(i_s_aruser),
    .o_addr(o_m_araddr), .o_id(o_m_arid), .o_len(o_m_arlen),
    .o_size(o_m_arsize), .o_burst(o_m_arburst), .o_lock(o_m_arlock),
    .o_cache(o_m_arcache), .o_prot(o_m_arprot), .o_user(o_m_aruser),
    .o_coherent(), .o_shape()
  );

  req_attr_capture #(.ADDR_W(ADDR_W), .ID_W(ID_W)) u_aw_cap (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_take(aw_take),
    .i_addr(i_s_awaddr), .i_id(i_s_awid), .i_len(i_s_awlen),
    .i_size(i_s_awsize), .i_burst(i_s_awburst), .i_lock(i_s_awlock),
    .i_cache(i_s_awcache), .i_prot(i_s_awprot), .i_user(i_s_awuser),
    .o_addr(o_m_awaddr), .o_id(o_m_awid), .o_len(o_m_awlen),
    .o_size(o_m_awsize), .o_burst(o_m_awburst), .o_lock(o_m_awlock),
    .o_cache(o_m_awcache), .o_prot(o_m_awprot), .o_user(o_m_awuser),
    .o_coherent(), .o_shape(aw_shape)
  );

  always_comb begin
    r_take_m = ce && (rd_state_ff == RD_DATA_M) && i_m_rvalid && o_m_rready;
    r_take_s = ce && (rd_state_ff == RD_DATA_S) && i_snoop_rvalid &&
               o_snoop_rready;
    r_out = ce && o_s_rvalid && i_s_rready;
    r_done = r_out && o_s_rlast;
    nxt_rvalid = (o_s_rvalid && !r_out) || r_take_m || r_take_s;
    w_take = ce && (wr_state_ff == WR_DATA) && i_s_wvalid && o_s_wready;
    w_out = ce && o_m_wvalid && i_m_wready;
    w_done = w_out && o_m_wlast;
    nxt_wvalid = (o_m_wvalid && !w_out) || w_take;
    b_take = ce && (wr_state_ff == WR_RESP) && i_m_bvalid && o_m_bready;
    b_out = ce && o_s_bvalid && i_s_bready;
    nxt_bvalid = (o_s_bvalid && !b_out) || b_take;
  end

  // read request sequencing
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_state_ff <= RD_IDLE;
      o_s_arready <= 1'b1;
      o_m_arvalid <= 1'b0;
      o_snoop_rd_req <= 1'b0;
      o_snoop_rd_opt <= 1'b0;
    end else begin
      case (rd_state_ff)
        RD_IDLE: begin
          if (ar_take) begin
            o_s_arready <= 1'b0;
            o_snoop_rd_req <= ar_coh;
            o_snoop_rd_opt <= ar_coh &&
                shape_ok(i_s_araddr[`CSP_LINE_OFS_W-1:0], i_s_arlen,
                         i_s_arsize, i_s_arburst);
            // plain reads go straight out
            rd_state_ff <= ar_coh ? RD_SNOOP : RD_ISSUE;
          end
        end
        RD_SNOOP: begin
          if (i_snoop_rd_ack) begin
            o_snoop_rd_req <= 1'b0;
            rd_state_ff <= i_snoop_rd_hit ? RD_DATA_S : RD_ISSUE;
          end
        end
        RD_ISSUE: begin
          if (ce) begin
            if (!o_m_arvalid) begin
              o_m_arvalid <= 1'b1;
            end else if (i_m_arready) begin
              o_m_arvalid <= 1'b0;
              rd_state_ff <= RD_DATA_M;
            end
          end
        end
        RD_DATA_M, RD_DATA_S: begin
          if (r_done) begin
            o_s_arready <= 1'b1;
            rd_state_ff <= RD_IDLE;
          end
        end
        default: rd_state_ff <= RD_IDLE;
      endcase
    end
  end

  // read data stage
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_s_rvalid <= 1'b0;
      o_s_rdata <= '0;
      o_s_rid <= '0;
      o_s_rresp <= `CSP_RESP_OKAY;
      o_s_rlast <= 1'b0;
      o_m_rready <= 1'b0;
      o_snoop_rready <= 1'b0;
    end else if (ce) begin
      o_s_rvalid <= nxt_rvalid;
      if (r_take_m) begin
        o_s_rdata <= i_m_rdata;
        o_s_rid <= i_m_rid;
        o_s_rresp <= i_m_rresp;
        o_s_rlast <= i_m_rlast;
      end else if (r_take_s) begin
        o_s_rdata <= i_snoop_rdata;
        o_s_rid <= o_m_arid;
        o_s_rresp <= `CSP_RESP_OKAY;
        o_s_rlast <= i_snoop_rlast;
      end
      o_m_rready <= (rd_state_ff == RD_DATA_M) && !nxt_rvalid && !r_done;
      o_snoop_rready <= (rd_state_ff == RD_DATA_S) && !nxt_rvalid &&
                        !r_done;
    end
  end

  // write request sequencing
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_state_ff <= WR_IDLE;
      o_s_awready <= 1'b1;
      o_m_awvalid <= 1'b0;
      o_snoop_wr_req <= 1'b0;
      o_snoop_wr_opt <= 1'b0;
    end else begin
      case (wr_state_ff)
        WR_IDLE: begin
          if (aw_take) begin
            o_s_awready <= 1'b0;
            wr_state_ff <= aw_coh ? WR_WAITW : WR_ISSUE;
          end
        end
        WR_WAITW: begin
          // first beat strobes pick opt path
          if (ce && i_s_wvalid) begin
            o_snoop_wr_req <= 1'b1;
            o_snoop_wr_opt <= aw_shape &&
                              (i_s_wstrb == `CSP_STRB_FULL);
            wr_state_ff <= WR_SNOOP;
          end
        end
        WR_SNOOP: begin
          if (i_snoop_wr_ack) begin
            o_snoop_wr_req <= 1'b0;
            wr_state_ff <= WR_ISSUE;
          end
        end
        WR_ISSUE: begin
          if (ce) begin
            if (!o_m_awvalid) begin
              o_m_awvalid <= 1'b1;
            end else if (i_m_awready) begin
              o_m_awvalid <= 1'b0;
              wr_state_ff <= WR_DATA;
            end
          end
        end
        WR_DATA: begin
          if (w_done) begin
            wr_state_ff <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (b_out) begin
            o_s_awready <= 1'b1;
            wr_state_ff <= WR_IDLE;
          end
        end
        default: wr_state_ff <= WR_IDLE;
      endcase
    end
  end

  // write data and response stages
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_m_wvalid <= 1'b0;
      o_m_wdata <= '0;
      o_m_wstrb <= '0;
      o_m_wlast <= 1'b0;
      o_s_wready <= 1'b0;
      o_s_bvalid <= 1'b0;
      o_s_bid <= '0;
      o_s_bresp <= `CSP_RESP_OKAY;
      o_m_bready <= 1'b0;
    end else if (ce) begin
      o_m_wvalid <= nxt_wvalid;
      if (w_take) begin
        o_m_wdata <= i_s_wdata;
        o_m_wstrb <= i_s_wstrb;
        o_m_wlast <= i_s_wlast;
      end
      o_s_wready <= (wr_state_ff == WR_DATA) && !nxt_wvalid && !w_done;
      o_s_bvalid <= nxt_bvalid;
      if (b_take) begin
        o_s_bid <= i_m_bid;
        o_s_bresp <= i_m_bresp;
      end
      o_m_bready <= (wr_state_ff == WR_RESP) && !nxt_bvalid && !b_out;
    end
  end

endmodule : coherency_slave_port_frontend
`default_nettype wire

//--- rtl/csp_defines.svh
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH

`define CSP_DATA_W 64
`define CSP_STRB_W 8
`define CSP_LEN_W 4
`define CSP_SIZE_W 3
`define CSP_BURST_W 2
`define CSP_LOCK_W 2
`define CSP_CACHE_W 4
`define CSP_PROT_W 3
`define CSP_USER_W 5
`define CSP_RESP_W 2

`define CSP_USER_SHARED_BIT 0
`define CSP_CACHE_MOD_BIT 1

`define CSP_OPT_LEN 4'h3
`define CSP_OPT_SIZE 3'h3
`define CSP_BURST_INCR 2'h1
`define CSP_BURST_WRAP 2'h2
`define CSP_LINE_OFS_W 5
`define CSP_DW_OFS_W 3
`define CSP_STRB_FULL 8'hff
`define CSP_RESP_OKAY 2'h0
`define CSP_LOCK_NORMAL 2'h0

`endif

//--- rtl/csp_pkg.sv
`include "csp_defines.svh"

package csp_pkg;

  typedef enum logic [2:0] {
    RD_IDLE, RD_SNOOP, RD_ISSUE, RD_DATA_M, RD_DATA_S
  } rd_state_type;

  typedef enum logic [2:0] {
    WR_IDLE, WR_WAITW, WR_SNOOP, WR_ISSUE, WR_DATA, WR_RESP
  } wr_state_type;

  // shared bit and modifiable bit both set
  function automatic logic is_coherent(
    input logic [`CSP_USER_W-1:0] user,
    input logic [`CSP_CACHE_W-1:0] cache
  );
    return user[`CSP_USER_SHARED_BIT] & cache[`CSP_CACHE_MOD_BIT];
  endfunction : is_coherent

  // four-doubleword wrap, or incr from a line start
  function automatic logic shape_ok(
    input logic [`CSP_LINE_OFS_W-1:0] ofs,
    input logic [`CSP_LEN_W-1:0] len,
    input logic [`CSP_SIZE_W-1:0] size,
    input logic [`CSP_BURST_W-1:0] burst
  );
    logic dw;
    dw = (len == `CSP_OPT_LEN) && (size == `CSP_OPT_SIZE);
    return dw && (((burst == `CSP_BURST_WRAP) &&
                   (ofs[`CSP_DW_OFS_W-1:0] == '0)) ||
                  ((burst == `CSP_BURST_INCR) && (ofs == '0)));
  endfunction : shape_ok

endpackage : csp_pkg

//--- rtl/req_attr_capture.sv
`timescale 1ns/1ps
`default_nettype none
`include "csp_defines.svh"

module req_attr_capture #(
  parameter int ADDR_W = 32,
  parameter int ID_W = 3
) (
  input wire logic i_clk, // core clock
  input wire logic i_nrst, // async reset, low
  input wire logic i_take, // address handshake
  input wire logic [ADDR_W-1:0] i_addr, // request address
  input wire logic [ID_W-1:0] i_id, // request id
  input wire logic [`CSP_LEN_W-1:0] i_len, // burst length
  input wire logic [`CSP_SIZE_W-1:0] i_size, // beat size
  input wire logic [`CSP_BURST_W-1:0] i_burst, // burst type
  input wire logic [`CSP_LOCK_W-1:0] i_lock, // lock attribute
  input wire logic [`CSP_CACHE_W-1:0] i_cache, // cache attribute
  input wire logic [`CSP_PROT_W-1:0] i_prot, // protection
  input wire logic [`CSP_USER_W-1:0] i_user, // user bits
  output logic [ADDR_W-1:0] o_addr, // held address
  output logic [ID_W-1:0] o_id, // held id
  output logic [`CSP_LEN_W-1:0] o_len, // held length
  output logic [`CSP_SIZE_W-1:0] o_size, // held size
  output logic [`CSP_BURST_W-1:0] o_burst, // held burst
  output logic [`CSP_LOCK_W-1:0] o_lock, // forwarded lock
  output logic [`CSP_CACHE_W-1:0] o_cache, // held cache
  output logic [`CSP_PROT_W-1:0] o_prot, // held prot
  output logic [`CSP_USER_W-1:0] o_user, // held user
  output logic o_coherent, // coherent flag
  output logic o_shape // optimized shape
);
  import csp_pkg::*;

  logic coh;

  assign coh = is_coherent(i_user, i_cache);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_addr <= '0;
      o_id <= '0;
      o_len <= '0;
      o_size <= '0;
      o_burst <= '0;
      o_lock <= `CSP_LOCK_NORMAL;
      o_cache <= '0;
      o_prot <= '0;
      o_user <= '0;
      o_coherent <= 1'b0;
      o_shape <= 1'b0;
    end else if (i_take) begin
      o_addr <= i_addr;
      o_id <= i_id;
      o_len <= i_len;
      o_size <= i_size;
      o_burst <= i_burst;
      // lock dropped when coherent
      o_lock <= coh ? `CSP_LOCK_NORMAL : i_lock;
      o_cache <= i_cache;
      o_prot <= i_prot;
      o_user <= i_user;
      o_coherent <= coh;
      o_shape <= shape_ok(i_addr[`CSP_LINE_OFS_W-1:0], i_len, i_size,
                          i_burst);
    end
  end

endmodule : req_attr_capture
`default_nettype wire

//--- sim/csp_props.sv
`timescale 1ns/1ps
`default_nettype none
module csp_props #(
  parameter int ADDR_W = 32,
  parameter int ID_W = 3
) (
  input wire logic i_clk, i_nrst, i_slave_port_clock_enable,
  input wire logic i_s_arvalid, o_s_arready, i_s_awvalid, o_s_awready,
  input wire logic [4:0] i_s_aruser, i_s_awuser, o_m_aruser, o_m_awuser,
  input wire logic [3:0] i_s_arcache, i_s_awcache, o_m_arcache, o_m_awcache,
  input wire logic [3:0] o_m_awlen,
  input wire logic [2:0] o_m_awsize,
  input wire logic [1:0] o_m_arlock, o_m_awlock,
  input wire logic o_s_rvalid, o_s_bvalid, o_m_arvalid, o_m_awvalid,
  input wire logic o_snoop_rd_req, o_snoop_wr_req, o_snoop_wr_opt
);
  logic en, rtk, wtk, rcoh, wcoh;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  assign en = i_slave_port_clock_enable;
  assign rtk = en && i_s_arvalid && o_s_arready;
  assign wtk = en && i_s_awvalid && o_s_awready;
  assign rcoh = i_s_aruser[0] && i_s_arcache[1];
  assign wcoh = i_s_awuser[0] && i_s_awcache[1];
  a_rd_coh_lookup: assert property (
    rtk && rcoh |=> o_snoop_rd_req && !o_m_arvalid)
    else $error("coherent read without lookup");
  a_rd_plain_pass: assert property (
    rtk && !rcoh |-> ##[1:8] (o_m_arvalid && !o_snoop_rd_req))
    else $error("plain read not forwarded");
  a_rd_lock_drop: assert property (
    o_m_arvalid && o_m_aruser[0] && o_m_arcache[1] |-> o_m_arlock == 2'h0)
    else $error("coherent read kept lock");
  a_wr_coh_clean: assert property (
    wtk && wcoh |-> ##[1:40] o_snoop_wr_req)
    else $error("coherent write without clean");
  a_wr_clean_first: assert property (
    o_snoop_wr_req |-> !o_m_awvalid)
    else $error("write issued before clean done");
  a_wr_lock_drop: assert property (
    o_m_awvalid && o_m_awuser[0] && o_m_awcache[1] |-> o_m_awlock == 2'h0)
    else $error("coherent write kept lock");
  a_wr_plain_pass: assert property (
    wtk && !wcoh |-> ##[1:8] (o_m_awvalid && !o_snoop_wr_req))
    else $error("plain write not forwarded");
  a_en_gated: assert property (
    !en |=> $stable(o_s_arready) && $stable(o_s_rvalid) && $stable(o_s_bvalid))
    else $error("slave output moved on disabled edge");
  a_wr_opt_shape: assert property (
    o_snoop_wr_req && o_snoop_wr_opt |-> o_m_awlen == 4'h3 && o_m_awsize == 3'h3)
    else $error("optimized write of wrong shape");
endmodule : csp_props
bind coherency_slave_port_frontend csp_props #(.ADDR_W(ADDR_W), .ID_W(ID_W))
  u_props (.*);
`default_nettype wire

//--- sim/csp_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module csp_far_model #(
  parameter int ID_W = 3,
  parameter logic [63:0] MEM_D = 64'h0,
  parameter logic [63:0] SNP_D = 64'h0
) (
  input wire logic i_clk, i_nrst, i_slave_port_clock_enable, i_hit,
  input wire logic o_m_arvalid, o_m_rready, o_m_awvalid, o_m_wvalid,
  input wire logic o_m_wlast, o_m_bready, o_snoop_rd_req, o_snoop_wr_req,
  input wire logic o_snoop_rready,
  input wire logic [3:0] o_m_arlen,
  input wire logic [ID_W-1:0] o_m_arid, o_m_awid,
  output logic i_m_arready, i_m_rvalid, i_m_rlast, i_m_awready,
  output logic i_m_wready, i_m_bvalid, i_snoop_rd_ack, i_snoop_rd_hit,
  output logic i_snoop_wr_ack, i_snoop_rvalid, i_snoop_rlast,
  output logic [63:0] i_m_rdata, i_snoop_rdata,
  output logic [ID_W-1:0] i_m_rid, i_m_bid,
  output logic [1:0] i_m_rresp, i_m_bresp
);
  logic sdat;
  logic [3:0] len, beat;
  assign i_m_rresp = 2'h0;
  assign i_m_bresp = 2'h0;
  // idle data lines show the inverse pattern
  assign i_m_rdata = i_m_rvalid ? (MEM_D | 64'(beat)) : ~MEM_D;
  assign i_snoop_rdata = i_snoop_rvalid ? (SNP_D | 64'(beat)) : ~SNP_D;
  assign i_m_rlast = i_m_rvalid && beat == len;
  assign i_snoop_rlast = i_snoop_rvalid && beat == len;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      {i_m_arready, i_m_rvalid, i_snoop_rvalid, sdat} <= '0;
      {i_m_awready, i_m_wready, i_m_bvalid} <= '0;
      {i_snoop_rd_ack, i_snoop_rd_hit, i_snoop_wr_ack} <= '0;
      {len, beat, i_m_rid, i_m_bid} <= '0;
    end else begin
      i_snoop_rd_ack <= o_snoop_rd_req && !i_snoop_rd_ack;
      i_snoop_rd_hit <= i_hit;
      i_snoop_wr_ack <= o_snoop_wr_req && !i_snoop_wr_ack;
      if (i_snoop_rd_ack && i_snoop_rd_hit) sdat <= 1'b1;
      if (i_slave_port_clock_enable) begin
        i_m_arready <= o_m_arvalid && !i_m_arready;
        i_m_awready <= o_m_awvalid && !i_m_awready;
        i_m_wready <= o_m_wvalid && !i_m_wready;
        if (o_m_arvalid && i_m_arready) begin
          {len, beat, i_m_rid, i_m_rvalid} <= {o_m_arlen, 4'h0, o_m_arid, 1'b1};
        end else if (sdat) begin
          {sdat, len, beat, i_snoop_rvalid} <= {1'b0, o_m_arlen, 4'h0, 1'b1};
        end else if (i_m_rvalid && o_m_rready) begin
          beat <= beat + 4'h1;
          i_m_rvalid <= !i_m_rlast;
        end else if (i_snoop_rvalid && o_snoop_rready) begin
          beat <= beat + 4'h1;
          i_snoop_rvalid <= !i_snoop_rlast;
        end
        if (o_m_awvalid && i_m_awready) i_m_bid <= o_m_awid;
        if (o_m_wvalid && i_m_wready && o_m_wlast) i_m_bvalid <= 1'b1;
        else if (o_m_bready) i_m_bvalid <= 1'b0;
      end
    end
  end
endmodule : csp_far_model
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [63:0] MEM_D = 64'hA5A5_0000_0000_0000;
  localparam logic [63:0] SNP_D = 64'h5A5A_0000_0000_0000;
  typedef struct packed {
    logic [4:0] u; logic [3:0] c; logic [1:0] lk; logic hit; logic [3:0] len;
    logic [7:0] st; logic coh; logic ro; logic wo;
  } row_type;
  logic i_clk, i_nrst, i_slave_port_clock_enable, i_s_arvalid, i_s_rready;
  logic i_s_awvalid, i_s_wvalid, i_s_wlast, i_s_bready, i_hit;
  logic [31:0] i_s_araddr, i_s_awaddr, o_m_araddr, o_m_awaddr;
  logic [2:0] i_s_arid, i_s_awid, o_s_rid, o_s_bid, o_m_arid, o_m_awid;
  logic [2:0] i_m_rid, i_m_bid, i_s_arsize, i_s_awsize, o_m_arsize;
  logic [2:0] o_m_awsize, i_s_arprot, i_s_awprot, o_m_arprot, o_m_awprot;
  logic [3:0] i_s_arlen, i_s_awlen, o_m_arlen, o_m_awlen;
  logic [3:0] i_s_arcache, i_s_awcache, o_m_arcache, o_m_awcache;
  logic [1:0] i_s_arburst, i_s_awburst, o_m_arburst, o_m_awburst, ar_lk;
  logic [1:0] i_s_arlock, i_s_awlock, o_m_arlock, o_m_awlock, aw_lk;
  logic [1:0] o_s_rresp, o_s_bresp, i_m_rresp, i_m_bresp;
  logic [4:0] i_s_aruser, i_s_awuser, o_m_aruser, o_m_awuser;
  logic [63:0] i_s_wdata, o_s_rdata, i_m_rdata, o_m_wdata, i_snoop_rdata, d0;
  logic [7:0] i_s_wstrb, o_m_wstrb;
  logic o_s_arready, o_s_rvalid, o_s_rlast, o_s_awready, o_s_wready;
  logic o_s_bvalid, o_m_arvalid, i_m_arready, i_m_rvalid, o_m_rready;
  logic i_m_rlast, o_m_awvalid, i_m_awready, o_m_wvalid, i_m_wready;
  logic o_m_wlast, i_m_bvalid, o_m_bready, o_snoop_rd_req, o_snoop_rd_opt;
  logic i_snoop_rd_ack, i_snoop_rd_hit, i_snoop_rvalid, o_snoop_rready;
  logic i_snoop_rlast, o_snoop_wr_req, o_snoop_wr_opt, i_snoop_wr_ack;
  logic seen_rq, rd_opt, seen_ar, seen_wq, wr_opt, aw_early;
  int failures, checks_done, cyc, ratio, ph, nb;
  // lock and exclusive on plain rows only
  row_type rows [5] = '{
    '{5'h00, 4'h2, 2'h2, 1'h0, 4'h3, 8'hff, 1'h0, 1'h0, 1'h0},
    '{5'h01, 4'h0, 2'h1, 1'h1, 4'h3, 8'hff, 1'h0, 1'h0, 1'h0},
    '{5'h01, 4'h2, 2'h0, 1'h0, 4'h3, 8'hff, 1'h1, 1'h1, 1'h1},
    '{5'h1f, 4'hf, 2'h0, 1'h1, 4'h3, 8'h7f, 1'h1, 1'h1, 1'h0},
    '{5'h03, 4'h3, 2'h0, 1'h1, 4'h1, 8'hff, 1'h1, 1'h0, 1'h0}};
  coherency_slave_port_frontend #(.ADDR_W(32), .ID_W(3)) uut (.*);
  csp_far_model #(.ID_W(3), .MEM_D(MEM_D), .SNP_D(SNP_D)) u_far (.*);
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    seen_rq <= seen_rq | o_snoop_rd_req;
    rd_opt <= rd_opt | (o_snoop_rd_req & o_snoop_rd_opt);
    seen_ar <= seen_ar | o_m_arvalid;
    seen_wq <= seen_wq | o_snoop_wr_req;
    wr_opt <= wr_opt | (o_snoop_wr_req & o_snoop_wr_opt);
    aw_early <= aw_early | (o_m_awvalid & !seen_wq);
    if (o_m_arvalid) ar_lk <= o_m_arlock;
    if (o_m_awvalid) aw_lk <= o_m_awlock;
    #1;
    ph = (ph + 1 >= ratio) ? 0 : ph + 1;
    i_slave_port_clock_enable = (ph == 0);
    cyc++;
    if (cyc > 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic check(input string nm, input logic [63:0] s, e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic set_req(input row_type r, input int i);
    {i_s_araddr, i_s_awaddr} = {2{32'(i * 32)}};
    {i_s_arid, i_s_awid, i_s_arprot, i_s_awprot} = {4{3'(i)}};
    {i_s_arlen, i_s_awlen, i_s_arcache, i_s_awcache} = {r.len, r.len, r.c, r.c};
    {i_s_arsize, i_s_awsize, i_s_arburst, i_s_awburst} = {6'h1b, 4'h5};
    {i_s_arlock, i_s_awlock, i_s_aruser, i_s_awuser} = {r.lk, r.lk, r.u, r.u};
    {i_s_wstrb, i_s_wdata, i_hit} = {r.st, 64'h0, r.hit};
  endtask : set_req
  task automatic rd(input row_type r, input int i);
    set_req(r, i);
    {nb, d0, i_s_arvalid, i_s_rready} = {32'h0, 64'h0, 2'h3};
    do @(posedge i_clk); while (!(i_slave_port_clock_enable && o_s_arready));
    #1 i_s_arvalid = 1'b0;
    do begin
      @(posedge i_clk);
      if (i_slave_port_clock_enable && o_s_rvalid) begin
        if (nb == 0) d0 = o_s_rdata;
        nb++;
      end
    end while (!(i_slave_port_clock_enable && o_s_rvalid && o_s_rlast));
    #1 i_s_rready = 1'b0;
  endtask : rd
  task automatic wr(input row_type r, input int i);
    set_req(r, i);
    i_s_awvalid = 1'b1;
    do @(posedge i_clk); while (!(i_slave_port_clock_enable && o_s_awready));
    #1 i_s_awvalid = 1'b0;
    for (int b = 0; b <= int'(r.len); b++) begin
      {i_s_wvalid, i_s_wdata, i_s_wlast} = {1'b1, 64'(b), b == int'(r.len)};
      do @(posedge i_clk); while (!(i_slave_port_clock_enable && o_s_wready));
      #1;
    end
    {i_s_wvalid, i_s_bready} = 2'h1;
    do @(posedge i_clk); while (!(i_slave_port_clock_enable && o_s_bvalid));
    check("bresp", o_s_bresp, 64'h0);
    #1 i_s_bready = 1'b0;
  endtask : wr
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    {i_nrst, i_s_arvalid, i_s_rready, i_s_awvalid, i_s_wvalid} = '0;
    {i_s_wlast, i_s_bready, i_slave_port_clock_enable, ph, cyc} = '0;
    {failures, checks_done, ratio} = {32'h0, 32'h0, 32'h1};
    set_req(rows[0], 0);
    repeat (8) @(posedge i_clk);
    check("arready in reset", o_s_arready, 64'h1);
    #1 i_nrst = 1'b1;
    for (int i = 0; i < 5; i++) begin
      ratio = 1 + i % 3;
      {seen_rq, rd_opt, seen_ar, seen_wq, wr_opt, aw_early} = '0;
      rd(rows[i], i);
      check("beats", nb, rows[i].len + 1);
      check("data", d0, rows[i].coh && rows[i].hit ? SNP_D : MEM_D);
      check("lookup", seen_rq, rows[i].coh);
      check("master ar", seen_ar, !(rows[i].coh && rows[i].hit));
      if (seen_ar) check("ar lock", ar_lk, rows[i].coh ? 2'h0 : rows[i].lk);
      check("rd opt", rd_opt, rows[i].ro);
      wr(rows[i], i);
      check("clean", seen_wq, rows[i].coh);
      check("aw early", aw_early, !rows[i].coh);
      check("aw lock", aw_lk, rows[i].coh ? 2'h0 : rows[i].lk);
      check("wr opt", wr_opt, rows[i].wo);
    end
    set_req(rows[2], 2);
    i_s_arvalid = 1'b1;
    repeat (3) @(posedge i_clk);
    #1 {i_nrst, i_s_arvalid} = 2'h0;
    #1 check("idle after reset", {o_s_arready, o_s_rvalid, o_snoop_rd_req}, 64'h4);
    @(posedge i_clk);
    #1 i_nrst = 1'b1;
    rd(rows[0], 0);
    check("data after reset", d0, MEM_D);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
